// *** hdl/tbt_defs.vh ***
// Constants of the 10 Mbps twisted-pair control block
`ifndef TBT_DEFS_VH
`define TBT_DEFS_VH
// ****************************************************************
// Timing
// ****************************************************************
`define TBT_CLK_MHZ      50
`define TBT_BT_NS        100
`define TBT_BT_CYC       ((`TBT_BT_NS * `TBT_CLK_MHZ + 999) / 1000)
`define TBT_HALF_CYC     (`TBT_BT_CYC / 2)
`define TBT_MID_MIN      ((3 * `TBT_BT_CYC + 3) / 4)
`define TBT_EOF_CYC      (2 * `TBT_BT_CYC)
`define TBT_SQE_BT       10
`define TBT_SQE_CYC      (`TBT_SQE_BT * `TBT_BT_CYC)
`define TBT_LP_MS        16
`define TBT_LP_CYC       (`TBT_LP_MS * `TBT_CLK_MHZ * 1000)
`define TBT_RXTO_MS      96
`define TBT_RXTO_CYC     (`TBT_RXTO_MS * `TBT_CLK_MHZ * 1000)
`define TBT_JAB_MS       20
`define TBT_JAB_CYC      (`TBT_JAB_MS * `TBT_CLK_MHZ * 1000)
`define TBT_UNJAB_MS     500
`define TBT_UNJAB_CYC    (`TBT_UNJAB_MS * `TBT_CLK_MHZ * 1000)
`define TBT_LP_INV_CNT   8
`define TBT_EOF_INV_CNT  4
`define TBT_PRE_BYTE     8'h55
`define TBT_SFD_BYTE     8'hd5
// ****************************************************************
// Registers
// ****************************************************************
`define TBT_REG_CTRL     4'h0
`define TBT_REG_STATUS   4'h4
`define TBT_REG_ISTAT    4'h8
`define TBT_REG_IMASK    4'hc
`define TBT_CTRL_RST     32'h00000000
`define TBT_CTRL_MASK    32'h000046a3
`define TBT_CTRL_LOOP    0
`define TBT_CTRL_AN      1
`define TBT_CTRL_PRE     5
`define TBT_CTRL_CRSS    7
`define TBT_CTRL_SQE     9
`define TBT_CTRL_JABD    10
`define TBT_CTRL_LITD    14
`define TBT_STAT_INV     0
`define TBT_STAT_JAB     1
`define TBT_STAT_LINK_A  2
`define TBT_STAT_LINK_B  10
`define TBT_IRQ_W        4
`define TBT_IRQ_UP       0
`define TBT_IRQ_FAIL     1
`define TBT_IRQ_JAB      2
`define TBT_IRQ_POL      3
`endif

// *** hdl/tbt_ctrl.v ***
// 10 Mbps twisted-pair transceiver control with Avalon-MM registers
`include "tbt_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module tbt_ctrl #(
  parameter [31:0] LP_CYC    = `TBT_LP_CYC,
  parameter [31:0] RXTO_CYC  = `TBT_RXTO_CYC,
  parameter [31:0] JAB_CYC   = `TBT_JAB_CYC,
  parameter [31:0] UNJAB_CYC = `TBT_UNJAB_CYC
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output wire [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  output wire        IRQ,
  // MII side
  output wire        TX_STB,
  input  wire [3:0]  TXD,
  input  wire        TX_EN,
  output wire        RX_STB,
  output wire [3:0]  RXD,
  output wire        RX_DV,
  output wire        CRS,
  output wire        COL,
  output wire        AN_RESTART,
  // Twisted pair
  output wire        TX_POS,
  output wire        TX_NEG,
  input  wire        RECEIVE_PAIR_POSITIVE,
  input  wire        RECEIVE_PAIR_NEGATIVE
);

  localparam [2:0] T_IDLE = 3'b001;
  localparam [2:0] T_DATA = 3'b010;
  localparam [2:0] T_EOF  = 3'b100;
  localparam [3:0] R_RUN  = 4'b0001;
  localparam [3:0] R_T1   = 4'b0010;
  localparam [3:0] R_T2   = 4'b0100;
  localparam [3:0] R_END  = 4'b1000;

  reg  [31:0] ctrl_r;
  reg  [31:0] rdata_r;
  reg         ack_r;
  reg  [3:0]  istat_r;
  reg  [3:0]  imask_r;
  reg  [1:0]  rp_s_r;
  reg  [1:0]  rn_s_r;
  reg  [1:0]  lv_r;
  reg         in_fr_r;
  reg  [7:0]  gap_r;
  reg  [7:0]  pw_r;
  reg         bit_stb_r;
  reg         bit_r;
  reg         eof_r;
  reg         eof_inv_r;
  reg         lp_r;
  reg         lp_inv_r;
  reg  [7:0]  hist_r;
  reg  [1:0]  bcnt_r;
  reg         nph_r;
  reg         align_r;
  reg  [3:0]  rst_r;
  reg  [3:0]  t_pend_r;
  reg  [3:0]  t_part_r;
  reg         t_keep_r;
  reg  [3:0]  rxd_r;
  reg         rx_dv_r;
  reg         crs_r;
  reg         rx_stb_r;
  reg         inv_r;
  reg  [3:0]  lpi_r;
  reg  [2:0]  eofi_r;
  reg  [31:0] sil_r;
  reg         link_r;
  reg  [7:0]  ph_r;
  reg  [1:0]  nb_r;
  reg  [2:0]  tst_r;
  reg  [3:0]  tsh_r;
  reg  [7:0]  tcnt_r;
  reg  [31:0] lpc_r;
  reg         lp_tx_r;
  reg         tx_p_r;
  reg         tx_n_r;
  reg  [7:0]  col_r;
  reg  [31:0] jcnt_r;
  reg  [31:0] ucnt_r;
  reg         jab_r;
  reg         an_r;

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  wire loop     = ctrl_r[`TBT_CTRL_LOOP];
  wire an_en    = ctrl_r[`TBT_CTRL_AN];
  wire pre_pass = ctrl_r[`TBT_CTRL_PRE];
  wire crs_sync = ctrl_r[`TBT_CTRL_CRSS];
  wire sqe_en   = ctrl_r[`TBT_CTRL_SQE];
  wire jab_dis  = ctrl_r[`TBT_CTRL_JABD];
  wire lit_dis  = ctrl_r[`TBT_CTRL_LITD];

  // ****************************************************************
  // Line receive: three-level detect and Manchester recovery
  // ****************************************************************
  wire rpos = rp_s_r[1] & ~rn_s_r[1];
  wire rneg = rn_s_r[1] & ~rp_s_r[1];
  // Polarity corrected level, bit 0 positive, bit 1 negative
  wire [1:0] lv = inv_r ? {rpos, rneg} : {rneg, rpos};
  wire trans = ((lv == 2'b01) && (lv_r == 2'b10)) || ((lv == 2'b10) && (lv_r == 2'b01));

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rp_s_r    <= 2'h0;
      rn_s_r    <= 2'h0;
      lv_r      <= 2'h0;
      in_fr_r   <= 1'b0;
      gap_r     <= 8'h00;
      pw_r      <= 8'h00;
      bit_stb_r <= 1'b0;
      bit_r     <= 1'b0;
      eof_r     <= 1'b0;
      eof_inv_r <= 1'b0;
      lp_r      <= 1'b0;
      lp_inv_r  <= 1'b0;
    end else begin
      rp_s_r    <= {rp_s_r[0], RECEIVE_PAIR_POSITIVE};
      rn_s_r    <= {rn_s_r[0], RECEIVE_PAIR_NEGATIVE};
      lv_r      <= lv;
      bit_stb_r <= 1'b0;
      eof_r     <= 1'b0;
      lp_r      <= 1'b0;
      if (!in_fr_r) begin
        if (lv == 2'b00) begin
          pw_r <= 8'h00;
          // Short isolated pulse is a link pulse; long holds are ignored
          if ((lv_r != 2'b00) && (pw_r <= `TBT_EOF_CYC)) begin
            lp_r     <= 1'b1;
            lp_inv_r <= lv_r[1];
          end
        end else begin
          if (pw_r != 8'hff)
            pw_r <= pw_r + 8'h01;
          if (trans) begin
            in_fr_r   <= 1'b1;
            gap_r     <= 8'h00;
            bit_stb_r <= 1'b1;
            bit_r     <= lv[0];
          end
        end
      end else if (trans && (gap_r >= `TBT_MID_MIN)) begin
        // Boundary transitions come too early and are skipped
        gap_r     <= 8'h00;
        bit_stb_r <= 1'b1;
        bit_r     <= lv[0];
      end else if (gap_r >= `TBT_EOF_CYC) begin
        in_fr_r   <= 1'b0;
        eof_r     <= 1'b1;
        eof_inv_r <= lv[1];
        pw_r      <= 8'hff;
      end else begin
        gap_r <= gap_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Receive nibble path, preamble handling and dribble bits
  // ****************************************************************
  wire [7:0] nh   = {bit_r, hist_r[7:1]};
  wire [7:0] shl  = hist_r << bcnt_r;
  wire [7:0] padw = {4'hf, hist_r[7:4]} >> (3'h4 - {1'b0, bcnt_r});
  wire       tick;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hist_r   <= 8'h00;
      bcnt_r   <= 2'h0;
      nph_r    <= 1'b0;
      align_r  <= 1'b0;
      rst_r    <= R_RUN;
      t_pend_r <= 4'h0;
      t_part_r <= 4'h0;
      t_keep_r <= 1'b0;
      rxd_r    <= 4'h0;
      rx_dv_r  <= 1'b0;
      crs_r    <= 1'b0;
      rx_stb_r <= 1'b0;
    end else begin
      rx_stb_r <= 1'b0;
      if (loop) begin
        rst_r   <= R_RUN;
        align_r <= 1'b0;
        hist_r  <= 8'h00;
        if (tick) begin
          rxd_r    <= TXD;
          rx_dv_r  <= TX_EN & ~jab_r;
          crs_r    <= TX_EN & ~jab_r;
          rx_stb_r <= 1'b1;
        end
      end else begin
        case (rst_r)
          R_RUN: begin
            if (eof_r) begin
              align_r <= 1'b0;
              bcnt_r  <= 2'h0;
              nph_r   <= 1'b0;
              hist_r  <= 8'h00;
              if (rx_dv_r) begin
                rst_r    <= R_T1;
                t_pend_r <= shl[7:4];
                t_part_r <= padw[3:0];
                t_keep_r <= (bcnt_r != 2'h0) & ~nph_r;
                if (!crs_sync)
                  crs_r <= 1'b0;
              end else begin
                crs_r <= 1'b0;
              end
            end else if (bit_stb_r) begin
              hist_r <= nh;
              if (!align_r) begin
                if (nh == `TBT_PRE_BYTE) begin
                  align_r <= 1'b1;
                  bcnt_r  <= 2'h0;
                  nph_r   <= 1'b0;
                end
              end else begin
                bcnt_r <= bcnt_r + 2'h1;
                if (bcnt_r == 2'h3) begin
                  nph_r <= ~nph_r;
                  // Output lags one nibble so SFD can be recognised whole
                  if (rx_dv_r | pre_pass | ((nh == `TBT_SFD_BYTE) & nph_r)) begin
                    rx_dv_r  <= 1'b1;
                    crs_r    <= 1'b1;
                    rxd_r    <= nh[3:0];
                    rx_stb_r <= 1'b1;
                  end
                end
              end
            end
          end
          R_T1: begin
            rxd_r    <= t_pend_r;
            rx_stb_r <= 1'b1;
            rst_r    <= t_keep_r ? R_T2 : R_END;
          end
          R_T2: begin
            rxd_r    <= t_part_r;
            rx_stb_r <= 1'b1;
            rst_r    <= R_END;
          end
          R_END: begin
            rx_dv_r <= 1'b0;
            crs_r   <= 1'b0;
            rst_r   <= R_RUN;
          end
          default: rst_r <= R_RUN;
        endcase
      end
    end
  end

  // ****************************************************************
  // Link integrity and polarity
  // ****************************************************************
  wire act     = lp_r | bit_stb_r;
  wire to_evt  = (sil_r == RXTO_CYC - 32'h1);
  wire up_evt  = lp_r & ~link_r;
  wire fail_ev = to_evt & link_r;
  wire lp_flip = lp_r & lp_inv_r & (lpi_r == `TBT_LP_INV_CNT - 1);
  wire ef_flip = eof_r & eof_inv_r & (eofi_r == `TBT_EOF_INV_CNT - 1);
  wire pol_ev  = ((lp_flip | ef_flip) & ~to_evt) | (to_evt & inv_r);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sil_r  <= 32'h0;
      link_r <= 1'b0;
      inv_r  <= 1'b0;
      lpi_r  <= 4'h0;
      eofi_r <= 3'h0;
      an_r   <= 1'b0;
    end else begin
      an_r <= fail_ev & an_en & ~lit_dis;
      if (act)
        sil_r <= 32'h0;
      else if (!to_evt)
        sil_r <= sil_r + 32'h1;
      if (lp_r)
        link_r <= 1'b1;
      else if (to_evt)
        link_r <= 1'b0;
      if (lp_r)
        lpi_r <= (lp_inv_r & ~lp_flip) ? lpi_r + 4'h1 : 4'h0;
      if (eof_r)
        eofi_r <= (eof_inv_r & ~ef_flip) ? eofi_r + 3'h1 : 3'h0;
      if (to_evt) begin
        inv_r  <= 1'b0;
        lpi_r  <= 4'h0;
        eofi_r <= 3'h0;
      end else if (lp_flip | ef_flip) begin
        inv_r <= ~inv_r;
      end
    end
  end

  // ****************************************************************
  // Transmit: bit timing, Manchester, link pulses, heartbeat
  // ****************************************************************
  // Half bit of 2.5 cycles cannot be exact; first half is shorter
  wire bt_en = (ph_r == `TBT_BT_CYC - 1);
  assign tick = bt_en & (nb_r == 2'h3);
  wire tx_ok  = (link_r | lit_dis) & ~jab_r & ~loop;
  wire dbit   = tsh_r[nb_r];
  wire first  = (ph_r < `TBT_HALF_CYC);
  wire dpos   = first ? ~dbit : dbit;
  wire pos_n  = ((tst_r == T_DATA) & dpos) | (tst_r == T_EOF) | lp_tx_r;
  wire neg_n  = (tst_r == T_DATA) & ~dpos;
  wire [31:0] sqe_len = `TBT_SQE_CYC;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_r    <= 8'h00;
      nb_r    <= 2'h0;
      tst_r   <= T_IDLE;
      tsh_r   <= 4'h0;
      tcnt_r  <= 8'h00;
      lpc_r   <= 32'h0;
      lp_tx_r <= 1'b0;
      tx_p_r  <= 1'b0;
      tx_n_r  <= 1'b0;
      col_r   <= 8'h00;
    end else begin
      ph_r   <= bt_en ? 8'h00 : ph_r + 8'h01;
      nb_r   <= bt_en ? nb_r + 2'h1 : nb_r;
      tx_p_r <= pos_n;
      tx_n_r <= neg_n;
      if (col_r != 8'h00)
        col_r <= col_r - 8'h01;
      if (lp_tx_r) begin
        tcnt_r <= tcnt_r + 8'h01;
        if (tcnt_r == `TBT_BT_CYC - 1)
          lp_tx_r <= 1'b0;
      end
      case (tst_r)
        T_IDLE: begin
          if (tick & TX_EN & tx_ok & ~lp_tx_r) begin
            tst_r <= T_DATA;
            tsh_r <= TXD;
            lpc_r <= 32'h0;
          end else if (lpc_r >= LP_CYC - 32'h1) begin
            lpc_r   <= 32'h0;
            lp_tx_r <= 1'b1;
            tcnt_r  <= 8'h00;
          end else begin
            lpc_r <= lpc_r + 32'h1;
          end
        end
        T_DATA: begin
          if (tick) begin
            if (TX_EN & tx_ok) begin
              tsh_r <= TXD;
            end else begin
              tst_r  <= T_EOF;
              tcnt_r <= 8'h00;
            end
          end
        end
        T_EOF: begin
          tcnt_r <= tcnt_r + 8'h01;
          if (tcnt_r == `TBT_EOF_CYC - 1) begin
            tst_r <= T_IDLE;
            if (sqe_en)
              col_r <= sqe_len[7:0];
          end
        end
        default: tst_r <= T_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Jabber
  // ****************************************************************
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      jcnt_r <= 32'h0;
      ucnt_r <= 32'h0;
      jab_r  <= 1'b0;
    end else if (jab_dis) begin
      jcnt_r <= 32'h0;
      ucnt_r <= 32'h0;
      jab_r  <= 1'b0;
    end else if (jab_r) begin
      jcnt_r <= 32'h0;
      ucnt_r <= ucnt_r + 32'h1;
      if (ucnt_r >= UNJAB_CYC - 32'h1)
        jab_r <= 1'b0;
    end else if (TX_EN) begin
      ucnt_r <= 32'h0;
      jcnt_r <= jcnt_r + 32'h1;
      if (jcnt_r >= JAB_CYC - 32'h1)
        jab_r <= 1'b1;
    end else begin
      jcnt_r <= 32'h0;
    end
  end

  // ****************************************************************
  // Register slave and interrupt
  // ****************************************************************
  wire req    = AVS_READ | AVS_WRITE;
  wire wr_acc = AVS_WRITE & ack_r;
  wire [3:0] ev;
  assign ev[`TBT_IRQ_UP]   = up_evt;
  assign ev[`TBT_IRQ_FAIL] = fail_ev;
  assign ev[`TBT_IRQ_JAB]  = jab_r ? 1'b0 : (TX_EN & ~jab_dis & (jcnt_r >= JAB_CYC - 32'h1));
  assign ev[`TBT_IRQ_POL]  = pol_ev;

  reg [31:0] status;
  always @* begin
    status = 32'h0;
    status[`TBT_STAT_INV]    = inv_r;
    status[`TBT_STAT_JAB]    = jab_r;
    status[`TBT_STAT_LINK_A] = link_r;
    status[`TBT_STAT_LINK_B] = link_r;
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r  <= `TBT_CTRL_RST;
      rdata_r <= 32'h0;
      ack_r   <= 1'b0;
      istat_r <= 4'h0;
      imask_r <= 4'h0;
    end else begin
      ack_r <= req & ~ack_r;
      if (AVS_READ & ~ack_r) begin
        case (AVS_ADDRESS)
          `TBT_REG_CTRL:   rdata_r <= ctrl_r;
          `TBT_REG_STATUS: rdata_r <= status;
          `TBT_REG_ISTAT:  rdata_r <= {28'h0, istat_r};
          `TBT_REG_IMASK:  rdata_r <= {28'h0, imask_r};
          default:         rdata_r <= 32'h0;
        endcase
      end
      if (wr_acc && (AVS_ADDRESS == `TBT_REG_CTRL))
        ctrl_r <= AVS_WRITEDATA & `TBT_CTRL_MASK;
      if (wr_acc && (AVS_ADDRESS == `TBT_REG_IMASK))
        imask_r <= AVS_WRITEDATA[3:0];
      // Set wins over a same-cycle write-one clear
      if (wr_acc && (AVS_ADDRESS == `TBT_REG_ISTAT))
        istat_r <= (istat_r & ~AVS_WRITEDATA[3:0]) | ev;
      else
        istat_r <= istat_r | ev;
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign IRQ             = |(istat_r & imask_r);
  assign TX_STB          = tick;
  assign RX_STB          = rx_stb_r;
  assign RXD             = rxd_r;
  assign RX_DV           = rx_dv_r;
  assign CRS             = crs_r;
  assign COL             = (col_r != 8'h00);
  assign AN_RESTART      = an_r;
  assign TX_POS          = tx_p_r;
  assign TX_NEG          = tx_n_r;

endmodule // tbt_ctrl

`default_nettype wire

// *** tb/tbt_ctrl_properties.sv ***
// Port-level checks for the 10 Mbps twisted-pair control block
`timescale 1ns/1ns
`default_nettype none
`include "tbt_defs.vh"
module tbt_ctrl_properties #(
  parameter [31:0] JAB_CYC   = 32'd300,
  parameter [31:0] UNJAB_CYC = 32'd300
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Register bus
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic        AVS_WAITREQUEST,
  // MII side
  input wire logic        TX_STB,
  input wire logic [3:0]  TXD,
  input wire logic        TX_EN,
  input wire logic        RX_STB,
  input wire logic [3:0]  RXD,
  input wire logic        RX_DV,
  input wire logic        CRS,
  input wire logic        COL,
  input wire logic        AN_RESTART,
  // Line
  input wire logic        TX_POS,
  input wire logic        TX_NEG
);
  logic [31:0] ctrl_r;
  logic [31:0] col_len_r;
  logic [31:0] en_cnt_r;
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Control mirror, since the register itself is not visible here
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r    <= 32'h0;
      col_len_r <= 32'h0;
      en_cnt_r  <= 32'h0;
    end else begin
      if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `TBT_REG_CTRL)
        ctrl_r <= AVS_WRITEDATA & `TBT_CTRL_MASK;
      col_len_r <= COL ? col_len_r + 32'h1 : 32'h0;
      en_cnt_r  <= TX_EN ? en_cnt_r + 32'h1 : 32'h0;
    end
  end
  bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  line_legal_a: assert property (!(TX_POS && TX_NEG))
    else $error("both line drives high");
  sqe_off_a: assert property (!ctrl_r[`TBT_CTRL_SQE] |-> !COL)
    else $error("heartbeat while disabled");
  sqe_len_a: assert property ($fell(COL) |-> col_len_r >= 32'd25 && col_len_r <= 32'd75)
    else $error("heartbeat length out of range");
  an_off_a: assert property (!ctrl_r[`TBT_CTRL_AN] |-> !AN_RESTART)
    else $error("negotiation restart while disabled");
  an_pulse_a: assert property (AN_RESTART |=> !AN_RESTART)
    else $error("negotiation restart too long");
  dv_crs_a: assert property ($rose(RX_DV) |-> CRS)
    else $error("valid without carrier");
  crs_sync_a: assert property (ctrl_r[`TBT_CTRL_CRSS] && $fell(RX_DV) |-> $fell(CRS))
    else $error("carrier not in step with valid");
  // Margin keeps the echo check clear of jabber entry
  loop_echo_a: assert property (ctrl_r[`TBT_CTRL_LOOP] && TX_STB && TX_EN
    && en_cnt_r + 32'd8 < JAB_CYC |=> RX_STB && RXD == $past(TXD))
    else $error("loopback nibble lost");
  jab_mute_a: assert property (!ctrl_r[`TBT_CTRL_JABD] && en_cnt_r > JAB_CYC + 32'd40
    && en_cnt_r < JAB_CYC + UNJAB_CYC |-> !TX_NEG)
    else $error("data sent in jabber");
endmodule // tbt_ctrl_properties
`default_nettype wire

// *** tb/tbt_mac_model.sv ***
// MAC model sending a preamble burst ending in the SFD nibble
`timescale 1ns/1ns
`default_nettype none
module tbt_mac_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench control
  input  wire logic       go,
  input  wire logic [7:0] len,
  output var  logic       busy,
  // MII transmit
  input  wire logic       tx_stb,
  output var  logic [3:0] txd,
  output var  logic       tx_en
);
  logic [7:0] cnt_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      cnt_r <= 8'h00;
      txd   <= 4'ha;
      tx_en <= 1'b0;
    end else if (go && !busy) begin
      busy  <= 1'b1;
      cnt_r <= 8'h00;
    end else if (tx_stb && busy) begin
      if (cnt_r < len) begin
        txd   <= (cnt_r == len - 8'h01) ? 4'hd : 4'h5;
        tx_en <= 1'b1;
        cnt_r <= cnt_r + 8'h01;
      end else begin
        // Stale nibble inverted so idle data never looks meaningful
        txd   <= ~txd;
        tx_en <= 1'b0;
        busy  <= 1'b0;
      end
    end
  end
endmodule // tbt_mac_model
`default_nettype wire

// *** tb/tb_tbt_ctrl.sv ***
// Self-checking bench for the 10 Mbps twisted-pair control block
`timescale 1ns/1ns
`default_nettype none
`include "tbt_defs.vh"
module tb_tbt_ctrl;
  // Short timers keep the run brief
  localparam [31:0] RXTO_T = 32'd2000;
  localparam [31:0] UNJ_T  = 32'd300;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         irq;
  wire         tx_stb;
  wire  [3:0]  txd;
  wire         tx_en;
  wire         rx_stb;
  wire  [3:0]  rxd;
  wire         rx_dv;
  wire         crs;
  wire         col;
  wire         an_restart;
  wire         tx_pos;
  wire         tx_neg;
  wire         mac_busy;
  logic        rp_pos = 1'b0;
  logic        rp_neg = 1'b0;
  logic        mac_go = 1'b0;
  logic [7:0]  mac_len = 8'h0;
  logic        lp_on = 1'b0;
  logic        lp_pol = 1'b1;
  // Own line fed back to the receiver
  logic        line_lb = 1'b0;
  logic        neg_seen = 1'b0;
  logic [31:0] rv;
  integer      pos_run = 0;
  integer      pos_len = 0;
  integer      col_run = 0;
  integer      col_len = 0;
  integer      an_cnt = 0;
  integer      err_total = 0;
  integer      tests_run = 0;
  integer      i;
  integer      n;
  always #10 clk = ~clk;
  tbt_ctrl #(.LP_CYC(32'd200), .RXTO_CYC(RXTO_T), .JAB_CYC(32'd300), .UNJAB_CYC(UNJ_T)) DUT (
    .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq), .TX_STB(tx_stb), .TXD(txd),
    .TX_EN(tx_en), .RX_STB(rx_stb), .RXD(rxd), .RX_DV(rx_dv), .CRS(crs), .COL(col),
    .AN_RESTART(an_restart), .TX_POS(tx_pos), .TX_NEG(tx_neg),
    .RECEIVE_PAIR_POSITIVE(line_lb ? tx_pos : rp_pos),
    .RECEIVE_PAIR_NEGATIVE(line_lb ? tx_neg : rp_neg));
  tbt_mac_model u_mac (.clk(clk), .rst_n(rst_n), .go(mac_go), .len(mac_len),
    .busy(mac_busy), .tx_stb(tx_stb), .txd(txd), .tx_en(tx_en));
  // Far-end link pulses, 5 CLK wide, polarity chosen by the bench
  always begin
    repeat (150) @(posedge clk);
    if (lp_on) begin
      rp_pos <= lp_pol;
      rp_neg <= !lp_pol;
      repeat (5) @(posedge clk);
      rp_pos <= 1'b0;
      rp_neg <= 1'b0;
    end
  end
  always @(posedge clk) begin
    pos_run <= (tx_pos === 1'b1) ? pos_run + 1 : 0;
    if (tx_pos !== 1'b1 && pos_run != 0) pos_len <= pos_run;
    col_run <= (col === 1'b1) ? col_run + 1 : 0;
    if (col !== 1'b1 && col_run != 0) col_len <= col_run;
    if (tx_neg === 1'b1) neg_seen <= 1'b1;
    if (an_restart === 1'b1) an_cnt <= an_cnt + 1;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bus(input wr_op, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr_op;
      avs_read <= !wr_op;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task go_mac(input [7:0] len);
    begin
      @(posedge clk);
      mac_len <= len;
      mac_go <= 1'b1;
      @(posedge clk);
      mac_go <= 1'b0;
    end
  endtask
  task wait_mac;
    begin
      @(posedge clk);
      while (mac_busy !== 1'b0) @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      bus(1'b0, `TBT_REG_CTRL, 32'h0);
      chk(rv, `TBT_CTRL_RST);
      bus(1'b0, `TBT_REG_IMASK, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      chk(rv, 32'h0);
      n = 0;
      while (pos_len == 0 && n < 400) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(pos_len, 32'd5);
      chk(neg_seen, 32'h0);
    end
  endtask
  task t_link;
    begin
      bus(1'b1, `TBT_REG_IMASK, 32'h1);
      lp_on = 1'b1;
      repeat (200) @(posedge clk);
      bus(1'b0, `TBT_REG_STATUS, 32'h0);
      chk(rv & 32'h404, 32'h404);
      chk(irq, 32'h1);
      bus(1'b1, `TBT_REG_ISTAT, 32'hf);
      @(posedge clk);
      chk(irq, 32'h0);
      bus(1'b1, `TBT_REG_IMASK, 32'h0);
    end
  endtask
  task t_loop;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        bus(1'b1, `TBT_REG_CTRL, p ? 32'ha1 : 32'h81);
        go_mac(8'd12);
        for (i = 0; i < 12; i = i + 1) begin
          n = 0;
          @(posedge clk);
          while (!(rx_stb === 1'b1 && rx_dv === 1'b1) && n < 100) begin
            @(posedge clk);
            n = n + 1;
          end
          chk(rxd, (i == 11) ? 32'hd : 32'h5);
        end
        wait_mac;
      end
      bus(1'b1, `TBT_REG_CTRL, 32'h0);
    end
  endtask
  task t_sqe;
    begin
      bus(1'b1, `TBT_REG_CTRL, 32'h200);
      neg_seen = 1'b0;
      go_mac(8'd8);
      wait_mac;
      repeat (120) @(posedge clk);
      chk(neg_seen, 32'h1);
      chk(col_len >= 25 && col_len <= 75, 32'h1);
      bus(1'b1, `TBT_REG_CTRL, 32'h0);
    end
  endtask
  task t_jab;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        bus(1'b1, `TBT_REG_CTRL, p ? 32'h400 : 32'h0);
        go_mac(8'd25);
        repeat (400) @(posedge clk);
        bus(1'b0, `TBT_REG_STATUS, 32'h0);
        chk(rv & 32'h2, p ? 32'h0 : 32'h2);
        wait_mac;
        repeat (UNJ_T + 200) @(posedge clk);
        bus(1'b0, `TBT_REG_STATUS, 32'h0);
        chk(rv & 32'h2, 32'h0);
      end
    end
  endtask
  task t_pol;
    begin
      bus(1'b1, `TBT_REG_CTRL, 32'h2);
      lp_pol = 1'b0;
      repeat (1600) @(posedge clk);
      bus(1'b0, `TBT_REG_STATUS, 32'h0);
      chk(rv & 32'h1, 32'h1);
      lp_on = 1'b0;
      i = an_cnt;
      repeat (RXTO_T + 300) @(posedge clk);
      bus(1'b0, `TBT_REG_STATUS, 32'h0);
      chk(rv & 32'h405, 32'h0);
      bus(1'b0, `TBT_REG_ISTAT, 32'h0);
      chk(rv & 32'h2, 32'h2);
      chk(an_cnt - i, 32'h1);
      bus(1'b1, `TBT_REG_CTRL, 32'h0);
    end
  endtask
  task t_litd;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        bus(1'b1, `TBT_REG_CTRL, p ? 32'h4000 : 32'h0);
        neg_seen = 1'b0;
        go_mac(8'd8);
        wait_mac;
        chk(neg_seen, p);
      end
    end
  endtask
  task t_rx;
    integer p;
    begin
      line_lb <= 1'b1;
      for (p = 0; p < 2; p = p + 1) begin
        bus(1'b1, `TBT_REG_CTRL, p ? 32'ha0 : 32'h0);
        repeat (450) @(posedge clk);
        go_mac(8'd12);
        i = 0;
        repeat (400) begin
          @(posedge clk);
          if (rx_stb === 1'b1 && rx_dv === 1'b1) begin
            if (i == 0) chk(rxd, 32'h5);
            i = i + 1;
            rv = rxd;
            n = crs;
          end
        end
        chk(i, p ? 32'd11 : 32'd2);
        chk(rv, 32'hd);
        chk(n, p);
      end
    end
  endtask
  task summarize;
    begin
      if (err_total == 0 && tests_run > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_link;
    t_loop;
    t_sqe;
    t_jab;
    t_pol;
    t_litd;
    t_rx;
    summarize;
  end
  // Expected run is near 9400 cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total = err_total + 1;
    summarize;
  end
endmodule // tb_tbt_ctrl
bind tbt_ctrl tbt_ctrl_properties #(.JAB_CYC(JAB_CYC), .UNJAB_CYC(UNJAB_CYC)) u_props (
  .CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TX_STB(TX_STB), .TXD(TXD), .TX_EN(TX_EN), .RX_STB(RX_STB), .RXD(RXD), .RX_DV(RX_DV),
  .CRS(CRS), .COL(COL), .AN_RESTART(AN_RESTART), .TX_POS(TX_POS), .TX_NEG(TX_NEG));
`default_nettype wire
